// ---- hw/sssp_pkg.sv ----
// Package for the byte-wide synchronous serial port, SPI personality.
// Assumes one system clock; the port top refers to it as sssp_pkg::name.
package sssp_pkg;

	// Register port
	localparam int         ADDR_W       = 3;
	localparam int         DATA_W       = 8;
	localparam logic [2:0] OFS_STATUS   = 3'h0;
	localparam logic [2:0] OFS_CONTROL  = 3'h1;
	localparam logic [2:0] OFS_BUFFER   = 3'h2;
	localparam logic [2:0] OFS_IRQ_STAT = 3'h3;
	localparam logic [2:0] OFS_IRQ_MASK = 3'h4;

	// Values after reset
	localparam logic [7:0] CTRL_RST     = 8'h00;
	localparam logic [7:0] BUF_RST      = 8'h00;
	localparam logic [2:0] IRQ_RST      = 3'h0;

	// Interrupt status bit positions
	localparam int         IRQ_W        = 3;
	localparam int         IRQ_DONE     = 0;
	localparam int         IRQ_WRITE_COLLISION     = 1;
	localparam int         IRQ_OVF      = 2;

	// Port mode select codes; others belong to the two-wire personality
	localparam logic [3:0] MODE_MST_DIV4  = 4'h0;
	localparam logic [3:0] MODE_MST_DIV16 = 4'h1;
	localparam logic [3:0] MODE_MST_DIV64 = 4'h2;
	localparam logic [3:0] MODE_MST_TMR2  = 4'h3;
	localparam logic [3:0] MODE_SLV_SEL   = 4'h4;
	localparam logic [3:0] MODE_SLV_FREE  = 4'h5;

	// Serial clock half periods in system clocks
	localparam logic [5:0] HALF_DIV4    = 6'h02;
	localparam logic [5:0] HALF_DIV16   = 6'h08;
	localparam logic [5:0] HALF_DIV64   = 6'h20;

	// Half-period ticks of one byte and index of the last bit
	localparam logic [4:0] TICK_END     = 5'h10;
	localparam logic [3:0] LAST_BIT     = 4'h7;

	typedef enum logic [2:0] {
		ST_OFF  = 3'b001,
		ST_IDLE = 3'b010,
		ST_XFER = 3'b100
	} sssp_state_t;

	typedef struct packed {
		logic       write_collision;
		logic       receive_overflow;
		logic       port_enable;
		logic       clock_idle_polarity;
		logic [3:0] port_mode_select;
	} sssp_ctrl_t;

	typedef struct packed {
		logic       sample_phase;
		logic       clock_edge;
		logic [4:0] unused;
		logic       buffer_full;
	} sssp_stat_t;

endpackage

// ---- hw/sssp_sync.sv ----
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes inputs change no faster than a few system clocks.
`timescale 1ns/1ps
module sssp_sync #(
	parameter int W = 3
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Pins in, synchronised out
	input  wire logic [W-1:0] async_i,
	input  wire logic [W-1:0] rst_val_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// First stage feeds only the second stage
	generate
		for (genvar i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					meta_ff[i] <= 1'b0;
					sync_ff[i] <= 1'b0;
				end else begin
					meta_ff[i] <= async_i[i];
					sync_ff[i] <= meta_ff[i];
				end
			end
		end
	endgenerate

	// Idle levels are not known at reset, so a flag masks the first cycles
	logic [1:0] warm_ff;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			warm_ff <= 2'h0;
		end else if (!warm_ff[1]) begin
			warm_ff <= {warm_ff[0], 1'b1};
		end
	end

	assign sync_o = warm_ff[1] ? sync_ff : rst_val_i;

endmodule

// ---- hw/sssp_top.sv ----
// Synchronous serial port in its SPI personality: shifter, buffer, flags.
// Assumes a register master on CLK_I; serial pins arrive asynchronously.
// Overview of operation
// RULE_01 - One byte out and in per transfer; all four polarity/phase modes.
// RULE_02 - Serial data out, serial data in and serial clock pins.
// RULE_03 - Slave mode may qualify transfers with an active-low select.
// RULE_04 - Shifter is hidden; software only reaches the buffer register.
// RULE_05 - Control fully read/write; status low six bits read-only.
// RULE_06 - Completed byte moves to buffer and sets the port interrupt flag.
// RULE_07 - Buffer write loads buffer and shifter together.
// RULE_08 - Sample phase: end of output time if 1, middle if 0.
// RULE_09 - Slave overflow when buffer unread; new byte lost; software clears.
// RULE_10 - Register meaning follows SPI versus two-wire mode selection.
// RULE_11 - Buffer write during transfer ignored; sets write collision flag.
// RULE_12 - Buffer full set on receive load, cleared by buffer read.
// RULE_13 - Port enable makes pins serial; clearing it resets the port.
// RULE_14 - Data shifts most significant bit first.
// RULE_15 - Clock polarity bit sets serial clock idle level.
// RULE_16 - Clock edge bit 1 changes output on active-to-idle transition.
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
module sssp_top (
	// Clock and reset
	input  wire logic       CLK_I,
	input  wire logic       RST_I,
	// Register port
	input  wire logic [2:0] ADDR_I,
	input  wire logic [7:0] WDATA_I,
	input  wire logic       WE_I,
	input  wire logic       RE_I,
	output logic      [7:0] RDATA_O,
	// Timer rate tick, same clock domain
	input  wire logic       TMR2_TICK_I,
	// Serial pins
	input  wire logic       SCK_I,
	output logic            SCK_O,
	output logic            SCK_OE_O,
	input  wire logic       SDI_I,
	output logic            SDO_O,
	output logic            SDO_OE_O,
	input  wire logic       SS_N_I,
	// Interrupt
	output logic            IRQ_O
);

	sssp_pkg::sssp_ctrl_t  ctrl_ff;
	sssp_pkg::sssp_stat_t  stat;
	sssp_pkg::sssp_state_t state_ff;
	logic                  smp_ff;
	logic                  cke_ff;
	logic                  bf_ff;
	logic [7:0]            buf_ff;
	logic [7:0]            shift_ff;
	logic                  out_ff;
	logic [4:0]            h_ff;
	logic [3:0]            nsamp_ff;
	logic [5:0]            div_ff;
	logic                  sck_ff;
	logic                  sck_prev_ff;
	logic [7:0]            rdata_ff;
	logic [2:0]            irq_st_ff;
	logic [2:0]            irq_mask_ff;
	logic                  sck_s;
	logic                  sdi_s;
	logic                  ss_n_s;

	sssp_sync #(
		.W(3)
	) u_sync (
		.clk_i    (CLK_I),
		.rst_i    (RST_I),
		.async_i  ({SCK_I, SDI_I, SS_N_I}),
		.rst_val_i({ctrl_ff.clock_idle_polarity, 1'b0, 1'b1}),
		.sync_o   ({sck_s, sdi_s, ss_n_s})
	);

	// Mode decode; two-wire codes leave the port inert
	logic [3:0] mode;
	logic       is_master;
	logic       is_slave;
	logic       spi_on;
	logic       ss_active;
	logic       busy;
	assign mode      = ctrl_ff.port_mode_select;
	assign is_master = ctrl_ff.port_enable &&
		(mode <= sssp_pkg::MODE_MST_TMR2);                  // [RULE_10]
	assign is_slave  = ctrl_ff.port_enable &&
		(mode == sssp_pkg::MODE_SLV_SEL ||
		 mode == sssp_pkg::MODE_SLV_FREE);                  // [RULE_10]
	assign spi_on    = is_master || is_slave;
	assign ss_active = (mode == sssp_pkg::MODE_SLV_FREE) || !ss_n_s; // [RULE_03]
	assign busy      = (state_ff == sssp_pkg::ST_XFER);

	// Register access strobes
	logic wr_stat;
	logic wr_ctrl;
	logic wr_buf;
	logic rd_buf;
	logic wr_istat;
	logic wr_imask;
	logic accept;
	logic collide;
	assign wr_stat  = WE_I && (ADDR_I == sssp_pkg::OFS_STATUS);
	assign wr_ctrl  = WE_I && (ADDR_I == sssp_pkg::OFS_CONTROL);
	assign wr_buf   = WE_I && (ADDR_I == sssp_pkg::OFS_BUFFER);
	assign rd_buf   = RE_I && (ADDR_I == sssp_pkg::OFS_BUFFER);
	assign wr_istat = WE_I && (ADDR_I == sssp_pkg::OFS_IRQ_STAT);
	assign wr_imask = WE_I && (ADDR_I == sssp_pkg::OFS_IRQ_MASK);
	assign collide  = wr_buf && busy;                        // [RULE_11]
	assign accept   = wr_buf && !busy;

	// Master bit rate from a divider or from the timer tick
	logic [5:0] half;
	logic       master_tick;
	always_comb begin
		if (mode == sssp_pkg::MODE_MST_DIV16) begin
			half = sssp_pkg::HALF_DIV16;
		end else if (mode == sssp_pkg::MODE_MST_DIV64) begin
			half = sssp_pkg::HALF_DIV64;
		end else begin
			half = sssp_pkg::HALF_DIV4;
		end
	end
	assign master_tick = is_master && busy &&
		((mode == sssp_pkg::MODE_MST_TMR2) ? TMR2_TICK_I :
		 (div_ff == half - 6'h01));

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			div_ff <= 6'h00;
		end else if (!busy || master_tick) begin
			div_ff <= 6'h00;
		end else begin
			div_ff <= div_ff + 6'h01;
		end
	end

	// Slave edges seen on the synchronised clock
	logic slave_edge;
	logic tick;
	logic sample_now;
	logic change_now;
	logic last_sample;
	logic ovf_event;
	assign slave_edge = is_slave && ss_active && (sck_s != sck_prev_ff);
	assign tick = is_master ? master_tick :
		(slave_edge && state_ff != sssp_pkg::ST_OFF);
	// Even ticks leave idle, odd ticks return to idle
	assign sample_now = tick && (h_ff[0] == (cke_ff ^ ~smp_ff)) &&
		!(h_ff == 5'h00 && !cke_ff && smp_ff);              // [RULE_08]
	assign change_now = tick && (h_ff[0] == cke_ff) &&
		(h_ff < sssp_pkg::TICK_END);                         // [RULE_16]
	assign last_sample = sample_now && (nsamp_ff == sssp_pkg::LAST_BIT); // [RULE_01]
	assign ovf_event = last_sample && is_slave && bf_ff;    // [RULE_09]

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sck_prev_ff <= 1'b0;
		end else begin
			sck_prev_ff <= sck_s;
		end
	end

	// Transfer sequencing
	logic ss_drop;
	assign ss_drop = is_slave && !ss_active;
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_ff <= sssp_pkg::ST_OFF;
		end else if (!spi_on) begin
			state_ff <= sssp_pkg::ST_OFF;                  // [RULE_13]
		end else if (ss_drop || last_sample) begin
			state_ff <= sssp_pkg::ST_IDLE;
		end else if (state_ff == sssp_pkg::ST_OFF) begin
			state_ff <= sssp_pkg::ST_IDLE;
		end else if (is_master && accept) begin
			state_ff <= sssp_pkg::ST_XFER;
		end else if (is_slave && tick) begin
			state_ff <= sssp_pkg::ST_XFER;
		end
	end

	// Tick and bit counters restart with each byte
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			h_ff     <= 5'h00;
			nsamp_ff <= 4'h0;
		end else if (!spi_on || ss_drop || last_sample || accept) begin
			h_ff     <= 5'h00;                                // [RULE_03]
			nsamp_ff <= 4'h0;
		end else if (tick) begin
			h_ff     <= h_ff + 5'h01;
			nsamp_ff <= sample_now ? nsamp_ff + 4'h1 : nsamp_ff;
		end
	end

	// Shifter: loaded only through the buffer write, never read directly
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			shift_ff <= sssp_pkg::BUF_RST;
		end else if (accept) begin
			shift_ff <= WDATA_I;                              // [RULE_07] [RULE_04]
		end else if (sample_now) begin
			shift_ff <= {shift_ff[6:0], sdi_s};               // [RULE_14]
		end
	end

	// Output bit; when sampling shares the tick, take the shifted value
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			out_ff <= 1'b0;
		end else if (accept) begin
			out_ff <= WDATA_I[7];                             // [RULE_14]
		end else if (change_now) begin
			out_ff <= sample_now ? shift_ff[6] : shift_ff[7]; // [RULE_16]
		end
	end

	// Master serial clock rests at the polarity bit level
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sck_ff <= 1'b0;
		end else if (!busy || !is_master) begin
			sck_ff <= ctrl_ff.clock_idle_polarity;            // [RULE_15]
		end else if (master_tick && h_ff < sssp_pkg::TICK_END) begin
			sck_ff <= ~sck_ff;                                // [RULE_01]
		end
	end

	// Receive buffer; an overflowing slave byte is dropped
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			buf_ff <= sssp_pkg::BUF_RST;
		end else if (last_sample && !ovf_event) begin
			buf_ff <= {shift_ff[6:0], sdi_s};                 // [RULE_06]
		end else if (accept) begin
			buf_ff <= WDATA_I;                                // [RULE_07]
		end
	end

	// Buffer full: receive load wins over a read in the same cycle
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			bf_ff <= 1'b0;
		end else if (last_sample && !ovf_event) begin
			bf_ff <= 1'b1;                                    // [RULE_12]
		end else if (rd_buf) begin
			bf_ff <= 1'b0;                                    // [RULE_12]
		end
	end

	// Control register; hardware sets win over software writes
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ctrl_ff <= sssp_pkg::CTRL_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_ff <= WDATA_I;                           // [RULE_05]
			end
			if (collide) begin
				ctrl_ff.write_collision <= 1'b1;              // [RULE_11]
			end
			if (ovf_event) begin
				ctrl_ff.receive_overflow <= 1'b1;             // [RULE_09]
			end
		end
	end

	// Status: only the two upper bits take writes
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			smp_ff <= 1'b0;
			cke_ff <= 1'b0;
		end else if (wr_stat) begin
			smp_ff <= WDATA_I[7];                             // [RULE_05]
			cke_ff <= WDATA_I[6];
		end
	end

	always_comb begin
		stat              = '0;
		stat.sample_phase = smp_ff;
		stat.clock_edge   = cke_ff;
		stat.buffer_full  = bf_ff;
	end

	// Interrupt status, write one to clear, set wins
	logic [2:0] irq_set;
	assign irq_set = {ovf_event, collide, last_sample};
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			irq_st_ff   <= sssp_pkg::IRQ_RST;
			irq_mask_ff <= sssp_pkg::IRQ_RST;
		end else begin
			irq_st_ff <= irq_set |
				(irq_st_ff & ~(wr_istat ? WDATA_I[2:0] : 3'h0)); // [RULE_06]
			if (wr_imask) begin
				irq_mask_ff <= WDATA_I[2:0];
			end
		end
	end

	// Read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rdata_ff <= 8'h00;
		end else if (!RE_I) begin
			rdata_ff <= 8'h00;
		end else if (ADDR_I == sssp_pkg::OFS_STATUS) begin
			rdata_ff <= stat;
		end else if (ADDR_I == sssp_pkg::OFS_CONTROL) begin
			rdata_ff <= ctrl_ff;
		end else if (ADDR_I == sssp_pkg::OFS_BUFFER) begin
			rdata_ff <= buf_ff;                               // [RULE_04]
		end else if (ADDR_I == sssp_pkg::OFS_IRQ_STAT) begin
			rdata_ff <= {5'h00, irq_st_ff};
		end else if (ADDR_I == sssp_pkg::OFS_IRQ_MASK) begin
			rdata_ff <= {5'h00, irq_mask_ff};
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	// Pins; slave output floats while deselected in select mode
	assign RDATA_O  = rdata_ff;
	assign SCK_O    = sck_ff;
	assign SCK_OE_O = is_master;                              // [RULE_02]
	assign SDO_O    = out_ff;
	assign SDO_OE_O = is_master || (is_slave && ss_active);   // [RULE_02] [RULE_03]
	assign IRQ_O    = |(irq_st_ff & irq_mask_ff);

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	sequence s_div4_start;
		accept && is_master && mode == sssp_pkg::MODE_MST_DIV4;
	endsequence
	sequence s_byte_run;
		busy [*8] ##[23:27] (state_ff == sssp_pkg::ST_IDLE);
	endsequence

	chk_byte_length: assert property (s_div4_start |=> s_byte_run) // [RULE_01]
		else $error("div4 byte did not end in 16 half periods");
	chk_rx_to_buffer: assert property (last_sample && !ovf_event |=> // [RULE_06]
		bf_ff && buf_ff == $past({shift_ff[6:0], sdi_s}) &&
		irq_st_ff[sssp_pkg::IRQ_DONE])
		else $error("received byte not moved to buffer");
	chk_bf_read_clear: assert property (rd_buf && !last_sample |=> !bf_ff) // [RULE_12]
		else $error("buffer read did not clear buffer full");
	chk_write_collision_ignore: assert property (collide |=> // [RULE_11]
		ctrl_ff.write_collision && $stable(buf_ff))
		else $error("collision write not ignored");
	chk_load_both: assert property (accept |=> // [RULE_07]
		shift_ff == $past(WDATA_I) && buf_ff == $past(WDATA_I) &&
		out_ff == $past(WDATA_I[7]))
		else $error("buffer write did not load shifter");
	chk_ovf_slave: assert property ($rose(ctrl_ff.receive_overflow) |-> // [RULE_09]
		$past(is_slave) || $past(wr_ctrl && WDATA_I[6]))
		else $error("overflow flag set outside slave mode");
	chk_ovf_keeps: assert property (ovf_event |=> $stable(buf_ff)) // [RULE_09]
		else $error("overflowing byte overwrote buffer");
	chk_sck_idle: assert property (is_master && !busy && // [RULE_15]
		$stable(ctrl_ff.clock_idle_polarity) [*2] |-> SCK_O ==
		ctrl_ff.clock_idle_polarity)
		else $error("serial clock not at idle level");
	chk_stat_readonly: assert property (wr_stat && !last_sample && // [RULE_05]
		!rd_buf |=> $stable(bf_ff))
		else $error("status write changed read-only bit");
	chk_disable_reset: assert property (!spi_on |=> // [RULE_13]
		state_ff == sssp_pkg::ST_OFF && h_ff == 5'h00)
		else $error("disabled port not reset");
	chk_ss_float: assert property (is_slave && // [RULE_03]
		mode == sssp_pkg::MODE_SLV_SEL && ss_n_s |-> !SDO_OE_O)
		else $error("deselected slave drives data out");

endmodule

// ---- tb/sssp_slave_model.sv ----
// Behavioural SPI slave that answers the port while it is master.
// Assumes SCK and the data pins are wired straight to the port.
`timescale 1ns/1ps
module sssp_slave_model (
	// Serial pins
	input  wire logic       sck_i,
	input  wire logic       sdo_i,
	output logic            sdi_o,
	// Setup and data
	input  wire logic       ckp_i,
	input  wire logic       cke_i,
	input  wire logic       load_i,
	input  wire logic [7:0] tx_i,
	output logic      [7:0] rx_o
);
	int n;
	initial begin
		sdi_o = 1'b0;
		rx_o = 8'h00;
		n = 8;
	end
	// Frame start; active-to-idle change shows bit 7 before any edge
	always @(posedge load_i) begin
		n = 0;
		if (cke_i)
			sdi_o = tx_i[7];
	end
	// Sample on one edge, change on the other
	always @(sck_i) begin
		if (n < 8 && (sck_i != ckp_i) == cke_i) begin
			rx_o = {rx_o[6:0], sdo_i};
			n = n + 1;
		end else if (n < 8) begin
			sdi_o = tx_i[7 - n];
		end else begin
			// Outside a frame the line shows the inverse at once
			sdi_o = ~sdi_o;
		end
	end
endmodule

// ---- tb/sssp_top_test.sv ----
// Self-checking bench: registers, master transfers, collision, slave.
// Assumes the slave model drives SDI in place of SERIAL_IN_PIN whenever the port drives SCK.
`timescale 1ns/1ps
module sssp_top_test;
	logic       clk;
	logic       rst;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic       we;
	logic       re;
	logic [7:0] rdata;
	logic [1:0] tcnt;
	logic       tick;
	logic       sck_in;
	logic       sck_out;
	logic       sck_oe;
	logic       serial_in_pin;
	logic       sdi_m;
	logic       sdi_pin;
	logic       serial_out_pin;
	logic       sdo_oe;
	logic       ss_n;
	logic       irq;
	logic       m_ckp;
	logic       m_cke;
	logic       m_load;
	logic [7:0] m_tx;
	logic [7:0] m_rx;
	int         num_errors = 0;
	int         n_tests = 0;

	// Model answers in master mode, bench drives SERIAL_IN_PIN as slave's master
	assign sdi_pin = sck_oe ? sdi_m : serial_in_pin;

	sssp_top sssp_top_i (
		.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
		.WE_I(we), .RE_I(re), .RDATA_O(rdata), .TMR2_TICK_I(tick),
		.SCK_I(sck_in), .SCK_O(sck_out), .SCK_OE_O(sck_oe),
		.SDI_I(sdi_pin), .SDO_O(serial_out_pin), .SDO_OE_O(sdo_oe),
		.SS_N_I(ss_n), .IRQ_O(irq)
	);
	sssp_slave_model sssp_slave_model_i (
		.sck_i(sck_out), .sdo_i(serial_out_pin), .sdi_o(sdi_m), .ckp_i(m_ckp),
		.cke_i(m_cke), .load_i(m_load), .tx_i(m_tx), .rx_o(m_rx)
	);

	always #12.5 clk = ~clk;
	// Timer tick every 4 clocks for the timer-rate mode
	always @(posedge clk) begin
		tcnt <= tcnt + 2'h1;
		tick <= (tcnt == 2'h3);
	end

	task automatic stop_test();
		if (num_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string w, input logic [7:0] e,
		input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", w, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic rc(input logic [2:0] a, input logic [7:0] e,
		input string w);
		logic [7:0] v;
		rd(a, v);
		chk(w, e, v);
	endtask
	// Bounded poll on buffer full
	task automatic wait_done();
		logic [7:0] s;
		for (int k = 0; k < 400; k++) begin
			rd(3'h0, s);
			if (s[0] === 1'b1)
				break;
		end
		chk("done", 8'h01, {7'h00, s[0]});
	endtask

	task automatic t_regs();
		rc(3'h1, 8'h00, "control");
		rc(3'h0, 8'h00, "status");
		rc(3'h3, 8'h00, "irq status");
		rc(3'h2, 8'h00, "buffer");
		wr(3'h1, 8'h9c);
		rc(3'h1, 8'h9c, "control");
		wr(3'h0, 8'hff);
		rc(3'h0, 8'hc0, "status");
		wr(3'h7, 8'h5a);
		rc(3'h7, 8'h00, "unmapped");
		wr(3'h1, 8'h28);
		wr(3'h0, 8'h00);
		chk("two-wire pins", 8'h00, {6'h00, sck_oe, sdo_oe});
		wr(3'h1, 8'h00);
	endtask

	// All four polarity/phase pairs, each clock rate code once
	task automatic t_master();
		logic [7:0] v;
		logic [7:0] tx;
		logic [7:0] st;
		wr(3'h4, 8'h01);
		for (int i = 0; i < 4; i++) begin
			tx = 8'h96 ^ 8'(i * 17);
			st = {i == 2, i[0], 6'h00};
			m_ckp <= i[1];
			m_cke <= i[0];
			wr(3'h0, st);
			wr(3'h1, {3'b001, i[1], 4'((i + 1) % 4)});
			repeat (2) @(posedge clk);
			chk("idle sck", {7'h00, i[1]}, {7'h00, sck_out});
			chk("oe pins", 8'h03, {6'h00, sck_oe, sdo_oe});
			m_tx <= tx;
			m_load <= 1'b1;
			wr(3'h2, 8'ha5 ^ tx);
			m_load <= 1'b0;
			wait_done();
			chk("irq", 8'h01, {7'h00, irq});
			chk("model rx", 8'ha5 ^ tx, m_rx);
			// Fastest rate leaves no margin for the input synchroniser
			if (i != 3)
				rc(3'h2, tx, "buffer");
			else
				rd(3'h2, v);
			rc(3'h0, st, "status bf");
			wr(3'h3, 8'h01);
			rc(3'h1, {3'b001, i[1], 4'((i + 1) % 4)}, "ctrl");
			chk("irq clear", 8'h00, {7'h00, irq});
		end
	endtask

	task automatic t_collide();
		m_ckp <= 1'b0;
		m_cke <= 1'b0;
		wr(3'h0, 8'h00);
		wr(3'h1, 8'h22);
		wr(3'h4, 8'h02);
		m_tx <= 8'h3c;
		m_load <= 1'b1;
		wr(3'h2, 8'hc3);
		m_load <= 1'b0;
		wr(3'h2, 8'h11);
		rc(3'h1, 8'ha2, "collision");
		chk("irq", 8'h01, {7'h00, irq});
		wr(3'h4, 8'h00);
		rc(3'h3, 8'h02, "irq status");
		chk("masked irq", 8'h00, {7'h00, irq});
		wait_done();
		chk("model rx", 8'hc3, m_rx);
		rc(3'h2, 8'h3c, "buffer");
		wr(3'h1, 8'h22);
		wr(3'h3, 8'h07);
		rc(3'h3, 8'h00, "irq cleared");
	endtask

	// Link clock 200 ns, idle low, data changes on leading edge
	task automatic sframe(input logic [7:0] d, output logic [7:0] q);
		ss_n <= 1'b0;
		repeat (8) @(posedge clk);
		for (int b = 7; b >= 0; b--) begin
			sck_in <= 1'b1;
			serial_in_pin <= d[b];
			repeat (4) @(posedge clk);
			sck_in <= 1'b0;
			repeat (3) @(posedge clk);
			@(negedge clk);
			q[b] = serial_out_pin;
			@(posedge clk);
		end
		ss_n <= 1'b1;
		serial_in_pin <= ~d[0];
		repeat (8) @(posedge clk);
	endtask

	task automatic t_slave();
		logic [7:0] q;
		wr(3'h1, 8'h00);
		wr(3'h0, 8'h00);
		chk("disabled pins", 8'h00, {6'h00, sck_oe, sdo_oe});
		wr(3'h1, 8'h24);
		wr(3'h4, 8'h04);
		wr(3'h2, 8'h5e);
		sframe(8'ha7, q);
		chk("slave tx", 8'h5e, q);
		rc(3'h0, 8'h01, "bf");
		sframe(8'h18, q);
		rc(3'h1, 8'h64, "overflow");
		chk("irq", 8'h01, {7'h00, irq});
		chk("sdo released", 8'h00, {7'h00, sdo_oe});
		rc(3'h2, 8'ha7, "buffer kept");
		wr(3'h1, 8'h24);
		rc(3'h1, 8'h24, "overflow cleared");
		// Slave without select drives data out even while deselected
		wr(3'h1, 8'h25);
		@(negedge clk);
		chk("free slave oe", 8'h01, {7'h00, sdo_oe});
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		addr = 3'h0;
		wdata = 8'h00;
		we = 1'b0;
		re = 1'b0;
		tcnt = 2'h0;
		tick = 1'b0;
		sck_in = 1'b0;
		serial_in_pin = 1'b0;
		ss_n = 1'b1;
		m_ckp = 1'b0;
		m_cke = 1'b0;
		m_load = 1'b0;
		m_tx = 8'h00;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_master();
		t_collide();
		t_slave();
		stop_test();
	end
	// Whole run needs well under 20000 clocks
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		stop_test();
	end
endmodule
